// ==== src/gcig_defs.vh ====
// constants for the companion two-wire bus master and receiver pins
`ifndef GCIG_DEFS_VH
`define GCIG_DEFS_VH
`define GCIG_A_CTRL 8'h00
`define GCIG_A_IOCFG 8'h04
`define GCIG_A_CMD 8'h08
`define GCIG_A_STAT 8'h0C
`define GCIG_A_ISTAT 8'h10
`define GCIG_A_IMASK 8'h14
`define GCIG_A_SYNCW 8'h18
`define GCIG_A_DIV 8'h1C
`define GCIG_A_IDX 8'h20
`define GCIG_CTRL_RST 32'h00000543
`define GCIG_FN_SUPPLY 3'h3
`define GCIG_FN_READY 3'h4
`define GCIG_FN_SYNC 3'h5
`define GCIG_IO_READY 8'h10
`define GCIG_IO_SYNC 8'h20
`define GCIG_MODE_BIT 12
`define GCIG_PSAVE_BIT 13
`define GCIG_AID_BIT 14
`define GCIG_CMD_START 8
`define GCIG_CMD_STOP 9
`define GCIG_CMD_READ 10
`define GCIG_CMD_NACK 11
`define GCIG_CMD_STORE 12
`define GCIG_IRQ_DONE 0
`define GCIG_IRQ_NACK 1
`define GCIG_IRQ_READY 2
`define GCIG_IRQ_RESTORE 3
`define GCIG_BUS_KHZ 16'h0064
`define GCIG_CLK_KHZ 16'h4E20
`define GCIG_DIV_RST (`GCIG_CLK_KHZ / (16'h0004 * `GCIG_BUS_KHZ))
`define GCIG_SYNCW_RST 16'h0001
`define GCIG_RESP_OK 2'h0
`define GCIG_RESP_ERR 2'h2
`endif

// ==== src/gcig_top.v ====
// two-wire bus master with receiver supply, data-ready and clock-sync pins
`include "gcig_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module gcig_top #(
    parameter STORE_AW = 4
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire scl_i,
    output reg scl_o,
    output reg scl_oe,
    input wire sda_i,
    output reg sda_o,
    output reg sda_oe,
    output reg receiver_supply_enable_pin,
    input wire receiver_data_ready_pin,
    output reg data_ready_pulldown_en,
    output reg clock_sync_share_pin,
    output reg idle_o,
    output reg wake_o,
    output reg irq
);
    localparam ST_IDLE = 5'h01;
    localparam ST_START = 5'h02;
    localparam ST_BIT = 5'h04;
    localparam ST_ACK = 5'h08;
    localparam ST_STOP = 5'h10;
    reg [31:0] ctrl_reg;
    reg [7:0] iocfg_reg;
    reg [3:0] istat_reg;
    reg [3:0] imask_reg;
    reg [15:0] syncw_reg;
    reg [15:0] div_reg;
    reg [STORE_AW-1:0] idx_reg;
    reg [7:0] store_mem [0:(1<<STORE_AW)-1];
    reg [7:0] aw_reg;
    reg aw_have;
    reg [31:0] w_reg;
    reg [3:0] ws_reg;
    reg w_have;
    reg [1:0] sync_s1;
    reg [2:0] s1_reg;
    reg [2:0] s2_reg;
    reg [4:0] state_reg;
    reg [1:0] q_reg;
    reg [2:0] bit_reg;
    reg [7:0] sh_reg;
    reg [7:0] rx_reg;
    reg stop_reg, rd_reg, nack_reg, st_reg, ackbad_reg;
    reg [15:0] cnt_reg;
    reg tick;
    reg [15:0] pcnt_reg;
    reg dr_prev, sup_prev;
    integer k;
    wire scl_s = s2_reg[0];
    wire sda_s = s2_reg[1];
    wire dr_s = s2_reg[2];
    wire wr_go = aw_have && w_have && !s_axi_bvalid;
    wire wr_full = (ws_reg == 4'hF);
    wire busy = (state_reg != ST_IDLE);
    wire mode_on = ctrl_reg[`GCIG_MODE_BIT];
    // data-ready sensing
    wire dr_func = (ctrl_reg[6:4] == `GCIG_FN_READY) && mode_on && (iocfg_reg == `GCIG_IO_READY);
    // sync sharing select
    wire sync_func = (ctrl_reg[10:8] == `GCIG_FN_SYNC) && mode_on && (iocfg_reg == `GCIG_IO_SYNC);
    // supply enable function
    wire sup_next = (ctrl_reg[2:0] == `GCIG_FN_SUPPLY) && mode_on;
    wire dr_rise = dr_func && dr_s && !dr_prev;
    wire sup_rise = sup_next && !sup_prev;
    wire cmd_go = wr_go && wr_full && (aw_reg == `GCIG_A_CMD) && !busy;
    wire byte_end = state_reg[3] && tick && (q_reg == 2'h3);
    wire ev_done = byte_end || (state_reg[4] && tick && (q_reg == 2'h2) && scl_s);
    wire ev_nack = byte_end && !rd_reg && ackbad_reg;
    wire [3:0] ev = {sup_rise && ctrl_reg[`GCIG_AID_BIT], dr_rise, ev_nack, ev_done && !ev_nack};
    wire wmap = (aw_reg <= `GCIG_A_IDX) && (aw_reg[1:0] == 2'h0);
    // input synchronisers, bus lines and data-ready
    genvar g;
    generate
        for (g = 0; g < 3; g = g + 1)
        begin : g_sync
            always @(posedge aclk)
            begin
                if (!aresetn)
                begin
                    s1_reg[g] <= 1'b1;
                    s2_reg[g] <= 1'b1;
                end
                else
                begin
                    s1_reg[g] <= (g == 0) ? scl_i : ((g == 1) ? sda_i : receiver_data_ready_pin);
                    s2_reg[g] <= s1_reg[g];
                end
            end
        end
    endgenerate
    // axi4-lite write channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GCIG_RESP_OK;
            aw_have <= 1'b0;
            w_have <= 1'b0;
            aw_reg <= 8'h00;
            w_reg <= 32'h00000000;
            ws_reg <= 4'h0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_reg <= s_axi_awaddr;
                aw_have <= 1'b1;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_reg <= s_axi_wdata;
                ws_reg <= s_axi_wstrb;
                w_have <= 1'b1;
                s_axi_wready <= 1'b0;
            end
            if (wr_go)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wmap ? `GCIG_RESP_OK : `GCIG_RESP_ERR;
                aw_have <= 1'b0;
                w_have <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end
    // axi4-lite read channel
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GCIG_RESP_OK;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `GCIG_RESP_OK;
            if (s_axi_araddr == `GCIG_A_CTRL)
                s_axi_rdata <= ctrl_reg;
            else if (s_axi_araddr == `GCIG_A_IOCFG)
                s_axi_rdata <= {24'h000000, iocfg_reg};
            else if (s_axi_araddr == `GCIG_A_CMD)
                s_axi_rdata <= 32'h00000000;
            else if (s_axi_araddr == `GCIG_A_STAT)
                s_axi_rdata <= {20'h00000, dr_s, idle_o, busy, ackbad_reg, rx_reg};
            else if (s_axi_araddr == `GCIG_A_ISTAT)
                s_axi_rdata <= {28'h0000000, istat_reg};
            else if (s_axi_araddr == `GCIG_A_IMASK)
                s_axi_rdata <= {28'h0000000, imask_reg};
            else if (s_axi_araddr == `GCIG_A_SYNCW)
                s_axi_rdata <= {16'h0000, syncw_reg};
            else if (s_axi_araddr == `GCIG_A_DIV)
                s_axi_rdata <= {16'h0000, div_reg};
            else if (s_axi_araddr == `GCIG_A_IDX)
                s_axi_rdata <= {{(32-STORE_AW){1'b0}}, idx_reg};
            else
            begin
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `GCIG_RESP_ERR;
            end
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
    // software registers and interrupt status
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= `GCIG_CTRL_RST;
            iocfg_reg <= 8'h00;
            imask_reg <= 4'h0;
            istat_reg <= 4'h0;
            syncw_reg <= `GCIG_SYNCW_RST;
            div_reg <= `GCIG_DIV_RST;
            irq <= 1'b0;
        end
        else
        begin
            if (wr_go && wr_full && aw_reg == `GCIG_A_CTRL)
                ctrl_reg <= w_reg;
            if (wr_go && wr_full && aw_reg == `GCIG_A_IOCFG)
                iocfg_reg <= w_reg[7:0];
            if (wr_go && wr_full && aw_reg == `GCIG_A_IMASK)
                imask_reg <= w_reg[3:0];
            // pulse width configurable, at least one
            if (wr_go && wr_full && aw_reg == `GCIG_A_SYNCW)
                syncw_reg <= (w_reg[15:0] == 16'h0000) ? 16'h0001 : w_reg[15:0];
            if (wr_go && wr_full && aw_reg == `GCIG_A_DIV)
                div_reg <= (w_reg[15:0] == 16'h0000) ? 16'h0001 : w_reg[15:0];
            if (wr_go && wr_full && aw_reg == `GCIG_A_ISTAT)
                istat_reg <= (istat_reg & ~w_reg[3:0]) | ev;
            else
                istat_reg <= istat_reg | ev;
            irq <= |(istat_reg & imask_reg);
        end
    end
    // quarter-bit divider
    always @(posedge aclk)
    begin
        if (!aresetn || !busy)
        begin
            cnt_reg <= 16'h0000;
            tick <= 1'b0;
        end
        else if (cnt_reg >= div_reg - 16'h0001)
        begin
            cnt_reg <= 16'h0000;
            tick <= 1'b1;
        end
        else
        begin
            cnt_reg <= cnt_reg + 16'h0001;
            tick <= 1'b0;
        end
    end
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_reg <= ST_IDLE;
            q_reg <= 2'h0;
            bit_reg <= 3'h7;
            sh_reg <= 8'h00;
            rx_reg <= 8'h00;
            stop_reg <= 1'b0;
            rd_reg <= 1'b0;
            nack_reg <= 1'b0;
            st_reg <= 1'b0;
            ackbad_reg <= 1'b0;
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
            idx_reg <= {STORE_AW{1'b0}};
        end
        else
        begin
            if (wr_go && wr_full && aw_reg == `GCIG_A_IDX)
                idx_reg <= w_reg[STORE_AW-1:0];
            // outputs stay low, only enables move
            scl_o <= 1'b0;
            sda_o <= 1'b0;
            case (state_reg)
                ST_IDLE:
                begin
                    q_reg <= 2'h0;
                    if (cmd_go)
                    begin
                        sh_reg <= w_reg[`GCIG_CMD_STORE] ? store_mem[idx_reg] : w_reg[7:0];
                        stop_reg <= w_reg[`GCIG_CMD_STOP];
                        rd_reg <= w_reg[`GCIG_CMD_READ];
                        nack_reg <= w_reg[`GCIG_CMD_NACK];
                        st_reg <= w_reg[`GCIG_CMD_STORE];
                        bit_reg <= 3'h7;
                        ackbad_reg <= 1'b0;
                        state_reg <= w_reg[`GCIG_CMD_START] ? ST_START : ST_BIT;
                    end
                end
                ST_START:
                    if (tick)
                    begin
                        q_reg <= q_reg + 2'h1;
                        if (q_reg == 2'h0)
                        begin
                            sda_oe <= 1'b0;
                            scl_oe <= 1'b0;
                        end
                        else if (q_reg == 2'h1)
                            sda_oe <= 1'b1;
                        else if (q_reg == 2'h2)
                        begin
                            scl_oe <= 1'b1;
                            q_reg <= 2'h0;
                            state_reg <= ST_BIT;
                        end
                    end
                ST_BIT, ST_ACK:
                    if (tick && !(q_reg == 2'h2 && !scl_s))
                    begin
                        q_reg <= q_reg + 2'h1;
                        if (q_reg == 2'h0)
                            sda_oe <= state_reg[2] ? (!rd_reg && !sh_reg[bit_reg]) : (rd_reg && !nack_reg);
                        else if (q_reg == 2'h1)
                            scl_oe <= 1'b0;
                        else if (q_reg == 2'h2)
                        begin
                            if (state_reg[2])
                                rx_reg <= {rx_reg[6:0], sda_s};
                            else
                                ackbad_reg <= sda_s;
                        end
                        else
                        begin
                            scl_oe <= 1'b1;
                            if (state_reg[2])
                            begin
                                bit_reg <= bit_reg - 3'h1;
                                if (bit_reg == 3'h0)
                                    state_reg <= ST_ACK;
                            end
                            else
                            begin
                                if (st_reg || (rd_reg && ctrl_reg[`GCIG_AID_BIT]))
                                    idx_reg <= idx_reg + {{(STORE_AW-1){1'b0}}, 1'b1};
                                state_reg <= (stop_reg || (!rd_reg && ackbad_reg)) ? ST_STOP : ST_IDLE;
                            end
                        end
                    end
                ST_STOP:
                    if (tick && !(q_reg == 2'h2 && !scl_s))
                    begin
                        q_reg <= q_reg + 2'h1;
                        if (q_reg == 2'h0)
                            sda_oe <= 1'b1;
                        else if (q_reg == 2'h1)
                            scl_oe <= 1'b0;
                        else if (q_reg == 2'h2)
                        begin
                            sda_oe <= 1'b0;
                            state_reg <= ST_IDLE;
                        end
                    end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end
    // store bytes read while aiding enabled
    always @(posedge aclk)
    begin
        if (byte_end && rd_reg && ctrl_reg[`GCIG_AID_BIT])
            store_mem[idx_reg] <= rx_reg;
    end
    // companion pins, idle and sync pulse
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            receiver_supply_enable_pin <= 1'b0;
            data_ready_pulldown_en <= 1'b1;
            clock_sync_share_pin <= 1'b0;
            idle_o <= 1'b0;
            wake_o <= 1'b0;
            dr_prev <= 1'b0;
            sup_prev <= 1'b0;
            pcnt_reg <= 16'h0000;
        end
        else
        begin
            receiver_supply_enable_pin <= sup_next;
            sup_prev <= sup_next;
            data_ready_pulldown_en <= !dr_func;
            dr_prev <= dr_func && dr_s;
            wake_o <= dr_rise && idle_o;
            if (dr_func && dr_s)
                idle_o <= 1'b0;
            else
                idle_o <= ctrl_reg[`GCIG_PSAVE_BIT] && !busy && !cmd_go;
            if (sup_rise && sync_func)
                pcnt_reg <= syncw_reg;
            else if (pcnt_reg != 16'h0000)
                pcnt_reg <= pcnt_reg - 16'h0001;
            clock_sync_share_pin <= sync_func && receiver_supply_enable_pin && (pcnt_reg != 16'h0000);
        end
    end
endmodule
`default_nettype wire

// ==== verification/gcig_asserts.sv ====
// port checker for the companion two-wire bus master
`include "gcig_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module gcig_asserts (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    input wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    input wire s_axi_wready,
    input wire scl_o,
    input wire scl_oe,
    input wire sda_o,
    input wire sda_oe,
    input wire receiver_supply_enable_pin,
    input wire data_ready_pulldown_en,
    input wire clock_sync_share_pin,
    input wire idle_o,
    input wire wake_o
);
    reg [31:0] ctrl_reg;
    reg [7:0] io_reg;
    reg [2:0] age_reg;
    reg cmd_reg;
    wire wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb == 4'hF;
    wire mode = ctrl_reg[`GCIG_MODE_BIT];
    wire steady = age_reg == 3'h7;
    wire sup_cfg = ctrl_reg[2:0] == `GCIG_FN_SUPPLY && mode;
    wire rdy_cfg = ctrl_reg[6:4] == `GCIG_FN_READY && mode && io_reg == `GCIG_IO_READY;
    wire syn_cfg = ctrl_reg[10:8] == `GCIG_FN_SYNC && mode && io_reg == `GCIG_IO_SYNC;
    // shadow of pin settings, aged since the last write
    always @(posedge aclk)
    begin
        if (!aresetn)
        begin
            ctrl_reg <= `GCIG_CTRL_RST;
            io_reg <= 8'h00;
            age_reg <= 3'h0;
            cmd_reg <= 1'b0;
        end
        else
        begin
            if (wr && s_axi_awaddr == `GCIG_A_CTRL)
                ctrl_reg <= s_axi_wdata;
            if (wr && s_axi_awaddr == `GCIG_A_IOCFG)
                io_reg <= s_axi_wdata[7:0];
            if (wr && s_axi_awaddr == `GCIG_A_CMD)
                cmd_reg <= 1'b1;
            age_reg <= wr ? 3'h0 : age_reg + {2'h0, age_reg != 3'h7};
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    lines_low_a: assert property (!scl_o && !sda_o)
        else $error("bus line driven high");
    quiet_bus_a: assert property (!cmd_reg |-> !scl_oe && !sda_oe)
        else $error("bus pulled without a command");
    supply_pin_a: assert property (steady |-> receiver_supply_enable_pin == sup_cfg)
        else $error("supply pin wrong");
    ready_pin_a: assert property (steady |-> data_ready_pulldown_en == !rdy_cfg)
        else $error("data-ready pin mode wrong");
    sync_low_a: assert property (steady && !syn_cfg |-> !clock_sync_share_pin)
        else $error("sync pin not low");
    sync_after_a: assert property ($rose(receiver_supply_enable_pin) && syn_cfg |-> ##[1:2] clock_sync_share_pin)
        else $error("no sync pulse after supply on");
    sync_width_a: assert property ($rose(clock_sync_share_pin) |-> receiver_supply_enable_pin ##1 !clock_sync_share_pin)
        else $error("sync pulse shape wrong");
    wake_pulse_a: assert property (wake_o |-> !data_ready_pulldown_en ##1 !wake_o)
        else $error("wake pulse wrong");
    idle_psave_a: assert property (steady && !ctrl_reg[`GCIG_PSAVE_BIT] |-> !idle_o)
        else $error("idle without power saving");
    cover property ($rose(clock_sync_share_pin));
    cover property (wake_o);
    cover property ($rose(sda_oe) && !scl_oe);
endmodule
`default_nettype wire

// ==== verification/gcig_slave_model.sv ====
// behavioural two-wire slave standing in for the receiver or a codec
`timescale 1ns/1ps
`default_nettype none
module gcig_slave_model #(
    parameter logic [6:0] ADDR = 7'h42,
    parameter logic [7:0] RDATA = 8'hA5,
    parameter int STRETCH_NS = 0
) (
    input wire logic scl,
    input wire logic sda,
    output logic scl_pull,
    output logic sda_pull,
    output logic [7:0] got_byte
);
    logic [7:0] sh = 8'h00;
    logic [3:0] bitn = 4'h0;
    logic act = 1'b0, first = 1'b0, sel = 1'b0, rd = 1'b0, ackph = 1'b0;
    initial
    begin
        scl_pull = 1'b0;
        sda_pull = 1'b0;
        got_byte = 8'h00;
    end
    always @(negedge sda)
        if (scl)
        begin
            {act, first, sel, ackph} = 4'b1100;
            bitn = 4'h0;
        end
    always @(posedge sda)
        if (scl)
            act = 1'b0;
    always @(posedge scl)
        if (act && ackph && rd && sda)
            sel = 1'b0;
        else if (act && !ackph && bitn < 4'h8)
        begin
            sh = {sh[6:0], sda};
            bitn = bitn + 4'h1;
        end
    always @(negedge scl)
        if (act)
        begin
            if (ackph)
            begin
                ackph = 1'b0;
                bitn = 4'h0;
            end
            else if (bitn == 4'h8)
            begin
                ackph = 1'b1;
                if (first)
                    {sel, rd} = {sh[7:1] == ADDR, sh[0]};
                else if (sel && !rd)
                    got_byte = sh;
            end
            sda_pull = ackph ? sel && (first || !rd) : sel && rd && !first && !RDATA[3'h7 - bitn[2:0]];
            if (ackph)
                first = 1'b0;
            if (STRETCH_NS > 0)
            begin
                scl_pull = 1'b1;
                #(STRETCH_NS);
                scl_pull = 1'b0;
            end
        end
endmodule
`default_nettype wire

// ==== verification/tb_top.sv ====
// self-checking bench for the companion bus master
`include "gcig_defs.vh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic aclk = 1'b0, aresetn = 1'b0, dready = 1'b0;
    logic [3:0] wstrb = 4'hF;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    wire awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe;
    wire supply, pd_en, sync, idle, wake, irq, p1_scl, p1_sda, p2_scl, p2_sda;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] p1_byte;
    wire scl = !(scl_oe || p1_scl || p2_scl);
    wire sda = !(sda_oe || p1_sda || p2_sda);
    int num_errors = 0, num_checks = 0, sync_cnt = 0, wake_cnt = 0;
    always #25 aclk = !aclk;
    always @(posedge aclk)
    begin
        if (sync === 1'b1)
            sync_cnt <= sync_cnt + 1;
        if (wake === 1'b1)
            wake_cnt <= wake_cnt + 1;
    end
    gcig_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .scl_i(scl), .scl_o(scl_o),
        .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .receiver_supply_enable_pin(supply),
        .receiver_data_ready_pin(dready), .data_ready_pulldown_en(pd_en), .clock_sync_share_pin(sync),
        .idle_o(idle), .wake_o(wake), .irq(irq));
    gcig_slave_model rcv (.scl(scl), .sda(sda),
        .scl_pull(p1_scl), .sda_pull(p1_sda), .got_byte(p1_byte));
    gcig_slave_model #(.ADDR(7'h1A), .RDATA(8'h3C), .STRETCH_NS(2000)) codec (.scl(scl), .sda(sda),
        .scl_pull(p2_scl), .sda_pull(p2_sda), .got_byte());
    task automatic finish_test;
        $display("errors %0d checks %0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task automatic hang;
        num_errors++;
        $display("mismatch at %0t wait ran out", $time);
        finish_test;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic pin(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = `GCIG_RESP_OK);
        int n;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge aclk);
            if (awvalid && awready)
                awvalid <= 1'b0;
            if (wvalid && wready)
                wvalid <= 1'b0;
            if (bvalid === 1'b1)
                break;
        end
        if (n == 200)
            hang;
        bready <= 1'b0;
        chk({30'h0, bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 200; n++)
        begin
            @(posedge aclk);
            if (arvalid && arready)
                arvalid <= 1'b0;
            if (rvalid === 1'b1)
                break;
        end
        if (n == 200)
            hang;
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er = `GCIG_RESP_OK);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic wt;
        repeat (6) @(posedge aclk);
    endtask
    // one bus step, then its status flags checked and cleared
    task automatic ic(input logic [31:0] v, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0] r;
        int n;
        wr(`GCIG_A_CMD, v);
        for (n = 0; n < 200; n++)
        begin
            rd(`GCIG_A_STAT, d, r);
            if (d[9] === 1'b0)
                break;
        end
        if (n == 200)
            hang;
        rc(`GCIG_A_ISTAT, e);
        wr(`GCIG_A_ISTAT, 32'hF);
    endtask
    initial
    begin
        logic [31:0] d;
        logic [1:0] r;
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        rc(`GCIG_A_CTRL, `GCIG_CTRL_RST);
        pin(supply, 1'b0);
        pin(pd_en, 1'b1);
        pin(sync, 1'b0);
        wstrb <= 4'h3;
        wr(`GCIG_A_CTRL, 32'h0);
        wstrb <= 4'hF;
        rc(`GCIG_A_CTRL, `GCIG_CTRL_RST);
        wr(8'h40, 32'h0, `GCIG_RESP_ERR);
        rc(8'h40, 32'h0, `GCIG_RESP_ERR);
        wr(`GCIG_A_IOCFG, 32'h20);
        wr(`GCIG_A_CTRL, `GCIG_CTRL_RST | 32'h5000);
        wt;
        pin(supply, 1'b1);
        chk(sync_cnt, 1);
        rc(`GCIG_A_ISTAT, 32'h8);
        wr(`GCIG_A_ISTAT, 32'hF);
        wr(`GCIG_A_CTRL, `GCIG_CTRL_RST);
        wt;
        pin(supply, 1'b0);
        wr(`GCIG_A_CTRL, 32'h1500);
        wr(`GCIG_A_IOCFG, 32'h10);
        wt;
        pin(supply, 1'b0);
        pin(pd_en, 1'b1);
        wr(`GCIG_A_CTRL, `GCIG_CTRL_RST | 32'h3000);
        wt;
        pin(pd_en, 1'b0);
        pin(idle, 1'b1);
        dready <= 1'b1;
        wt;
        chk(wake_cnt, 1);
        pin(idle, 1'b0);
        rc(`GCIG_A_ISTAT, 32'h4);
        wr(`GCIG_A_IMASK, 32'h4);
        wt;
        pin(irq, 1'b1);
        wr(`GCIG_A_IMASK, 32'h0);
        wt;
        pin(irq, 1'b0);
        wr(`GCIG_A_IMASK, 32'h4);
        wr(`GCIG_A_ISTAT, 32'h4);
        wt;
        pin(irq, 1'b0);
        rc(`GCIG_A_ISTAT, 32'h0);
        dready <= 1'b0;
        wr(`GCIG_A_CTRL, `GCIG_CTRL_RST);
        wr(`GCIG_A_DIV, 32'h2);
        ic(32'h184, 32'h1);
        ic(32'h25A, 32'h1);
        chk({24'h0, p1_byte}, 32'h5A);
        ic(32'h334, 32'h1);
        ic(32'h126, 32'h3);
        wr(`GCIG_A_CTRL, `GCIG_CTRL_RST | 32'h4000);
        wr(`GCIG_A_IDX, 32'h0);
        ic(32'h185, 32'h1);
        ic(32'hE00, 32'h1);
        rd(`GCIG_A_STAT, d, r);
        chk(d & 32'hFF, 32'hA5);
        rc(`GCIG_A_IDX, 32'h1);
        wr(`GCIG_A_IDX, 32'h0);
        ic(32'h184, 32'h1);
        ic(32'h1200, 32'h1);
        chk({24'h0, p1_byte}, 32'hA5);
        rc(`GCIG_A_IDX, 32'h1);
        finish_test;
    end
endmodule
bind gcig_top gcig_asserts chk_i (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .receiver_supply_enable_pin(receiver_supply_enable_pin),
    .data_ready_pulldown_en(data_ready_pulldown_en), .clock_sync_share_pin(clock_sync_share_pin),
    .idle_o(idle_o), .wake_o(wake_o));
`default_nettype wire
